// file: rtl/fft_ear_defines.svh
/*
 Constants of the FFT ear-model front end: framing, table formats and
 fixed-point positions. Assumes inclusion by bare name from rtl/.
*/
`ifndef FFT_EAR_DEFINES_SVH
`define FFT_EAR_DEFINES_SVH

`define SAMPLE_W 16
`define NUM_PATHS 4
`define FRAME_LEN 2048
`define HOP_LEN 1024
`define RING_DEPTH 3072
`define NUM_LINES 1025
`define LINE_W 11
`define RING_AW 12
`define HOP_W 10
`define MAG_W 32
`define ACC_W 48
`define XW_W 18
`define SC_W 32
`define WIN_FRAC 14
`define TRIG_FRAC 15
`define GAIN_FRAC 16
`define FAC_FRAC 16
`define OUT_FRAC 8
`define DFT_SHIFT 11
// Clocks from one line pulse to the next: MAC, drain, scale, square, root, weight, emit
`define LINE_GAP 2089
`define QUARTER_TURN 512
`define LINE_SPACING_HZ 23.4375
`define SPL_DEFAULT_DB 92.0
`define NORM_DEFAULT 10000.0

`endif

// file: rtl/fft_ear_pkg.sv
/*
 Types of the FFT ear-model front end: stream carriers and engine states.
 Assumes fft_ear_defines.svh is on the include path.
*/
`include "fft_ear_defines.svh"

package fft_ear_pkg;

   // Path order: 0 ref left, 1 ref right, 2 test left, 3 test right
   typedef struct packed {
      logic valid;
      logic [`NUM_PATHS-1:0][`SAMPLE_W-1:0] path;
   } sample_in_t;

   typedef struct packed {
      logic valid;
      logic [`LINE_W-1:0] line;
      logic [`NUM_PATHS-1:0][`MAG_W-1:0] mag;
   } line_out_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_MAC    = 3'b001,
      ST_DRAIN  = 3'b010,
      ST_SCALE  = 3'b011,
      ST_SQUARE = 3'b100,
      ST_SQRT   = 3'b101,
      ST_WEIGHT = 3'b110,
      ST_EMIT   = 3'b111
   } eng_state_t;

endpackage

// file: rtl/ear_tables.sv
/*
 Constant tables: analysis window, sine wave and ear weighting gain,
 each read through one register stage. Assumes the caller keeps the line
 address at or below the last spectral line.
*/
`include "fft_ear_defines.svh"

module ear_tables #(
   parameter real SPACING_HZ = `LINE_SPACING_HZ
)(
   input wire logic clock,
   input wire logic [`LINE_W-1:0] time_idx,
   input wire logic [`LINE_W-1:0] phase,
   input wire logic [`LINE_W-1:0] line,
   output logic [15:0] win,
   output logic signed [15:0] cos_v,
   output logic signed [15:0] sin_v,
   output logic [31:0] gain
);
   localparam real PI = 3.14159265358979323846;
   logic [15:0] win_rom [`FRAME_LEN];
   logic signed [15:0] sin_rom [`FRAME_LEN];
   logic [31:0] gain_rom [`NUM_LINES];
   logic [`LINE_W-1:0] cos_idx;

   generate
      for (genvar i = 0; i < `FRAME_LEN; i++)
      begin : g_trig
         // Scaled so the window has unit power; denominator N-1
         localparam real WV = 0.5 * $sqrt(8.0 / 3.0)
            * (1.0 - $cos(2.0 * PI * i / (`FRAME_LEN - 1.0)));
         localparam real SV = $sin(2.0 * PI * i / `FRAME_LEN);
         assign win_rom[i] = 16'($rtoi(WV * (2.0 ** `WIN_FRAC) + 0.5)); // [R03]
         assign sin_rom[i] = 16'(int'(SV * ((2.0 ** `TRIG_FRAC) - 1.0)));
      end
      for (genvar j = 0; j < `NUM_LINES; j++)
      begin : g_gain
         // Line 0 has no finite weight; its gain is forced to zero
         localparam real F = (j == 0) ? 1.0 : j * SPACING_HZ / 1000.0; // [R09]
         localparam real W = -0.6 * 3.64 * $pow(F, -0.8)
            + 6.5 * $exp(-0.6 * (F - 3.3) * (F - 3.3))
            - 0.001 * $pow(F, 3.6); // [R08]
         localparam real G = $pow(10.0, W / 20.0);
         assign gain_rom[j] = (j == 0) ? 32'h0000_0000
            : 32'($rtoi(G * (2.0 ** `GAIN_FRAC) + 0.5)); // [R10]
      end
   endgenerate

   assign cos_idx = phase + `LINE_W'(`QUARTER_TURN);

   always_ff @(posedge clock)
   begin
      win <= win_rom[time_idx];
      sin_v <= sin_rom[phase];
      cos_v <= sin_rom[cos_idx];
      gain <= gain_rom[line];
   end
endmodule

// file: rtl/int_sqrt.sv
/*
 Sequential integer square root, one result bit per clock.
 Assumes start is a one-cycle pulse and is not repeated while busy.
*/
module int_sqrt #(
   parameter int IN_W = 64
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [IN_W-1:0] radicand,
   output logic [IN_W/2-1:0] root,
   output logic done
);
   localparam int H = IN_W / 2;
   logic [IN_W-1:0] x_r, x_nxt;
   logic [H+1:0] rem_r, rem_nxt, rem_t, trial;
   logic [H-1:0] q_r, q_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic done_nxt;

   always_comb
   begin
      x_nxt = x_r;
      rem_nxt = rem_r;
      q_nxt = q_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      rem_t = {rem_r[H-1:0], x_r[IN_W-1 -: 2]};
      trial = {q_r, 2'b01};
      if (start)
      begin
         x_nxt = radicand;
         rem_nxt = '0;
         q_nxt = '0;
         cnt_nxt = 7'(H);
      end
      else if (cnt_r != 7'h00)
      begin
         x_nxt = {x_r[IN_W-3:0], 2'b00};
         cnt_nxt = cnt_r - 7'h01;
         done_nxt = (cnt_r == 7'h01);
         if (rem_t >= trial)
         begin
            rem_nxt = rem_t - trial;
            q_nxt = {q_r[H-2:0], 1'b1};
         end
         else
         begin
            rem_nxt = rem_t;
            q_nxt = {q_r[H-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         x_r <= '0;
         rem_r <= '0;
         q_r <= '0;
         cnt_r <= '0;
         done <= 1'b0;
      end
      else
      begin
         x_r <= x_nxt;
         rem_r <= rem_nxt;
         q_r <= q_nxt;
         cnt_r <= cnt_nxt;
         done <= done_nxt;
      end
   end

   assign root = q_r;
endmodule

// file: rtl/fft_ear_frontend.sv
/*
 FFT ear-model front end: frames four sample streams, windows them, takes
 a normalised DFT per line, scales to playback level, weights by the ear
 response and emits magnitudes line by line for all paths together.
 Assumes one sample set per valid, at most one per 4166 clocks (48 kHz).
*/
// Contract
// R01 - Source delivers aligned 48 kHz reference, test
// R02 - 2048-sample frames, new frame every 1024
// R03 - Hann window scaled half root eight-thirds
// R04 - 2048-point DFT, each coefficient divided by 2048
// R05 - Scale by ten^(level/20) over normalisation constant
// R06 - Normalisation is peak of 1019.5 Hz sine
// R07 - Unknown playback level: use 92 dB
// R08 - Apply outer and middle ear gain curve
// R09 - Line k sits at k times 23.4375 Hz
// R10 - Output magnitude of weighted scaled coefficient
// R11 - Channels processed separately, identically, independently
// R12 - Reference and test spectra offered for error path
// R13 - Strobe, line index, same frame order everywhere
`include "fft_ear_defines.svh"

module fft_ear_frontend #(
   parameter real FULL_SCALE_SPL_LEVEL = `SPL_DEFAULT_DB,
   parameter real NORM = `NORM_DEFAULT
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire fft_ear_pkg::sample_in_t sample_in,
   output fft_ear_pkg::line_out_t line_out,
   output logic frame_drop,
   output logic busy
);
   localparam logic [`LINE_W-1:0] T_LAST = `LINE_W'(`FRAME_LEN - 1);
   localparam logic [`LINE_W-1:0] K_LAST = `LINE_W'(`NUM_LINES - 1);
   localparam logic [`HOP_W-1:0] HOP_LAST = `HOP_W'(`HOP_LEN - 1);
   localparam logic [`RING_AW:0] RING_D = (`RING_AW+1)'(`RING_DEPTH);
   localparam logic [`RING_AW:0] BASE_OFS = (`RING_AW+1)'(`RING_DEPTH - `FRAME_LEN + 1);
   localparam real FAC_REAL = $pow(10.0, FULL_SCALE_SPL_LEVEL / 20.0) / NORM;
   localparam logic [31:0] FAC_Q = 32'($rtoi(FAC_REAL * (2.0 ** `FAC_FRAC) + 0.5)); // [R05] [R07]
   fft_ear_pkg::eng_state_t state_r, state_nxt;
   logic [`LINE_W-1:0] t_r, t_nxt, k_r, k_nxt, phase_r, phase_nxt;
   logic [`RING_AW-1:0] base_r, base_nxt, wr_r, wr_nxt, pend_base_r, pend_base_nxt;
   logic [`RING_AW-1:0] rd_addr, frame_base;
   logic [`RING_AW:0] rd_sum, base_sum;
   logic [`HOP_W-1:0] hop_r, hop_nxt;
   logic primed_r, primed_nxt, pend_r, pend_nxt, drop_r, drop_nxt;
   logic v1_r, v1_nxt, v2_r, v2_nxt, sq_go_r, sq_go_nxt, busy_r, busy_nxt;
   logic go, consume, acc_clr;
   logic signed [15:0] cos2_r, cos2_nxt, sin2_r, sin2_nxt;
   fft_ear_pkg::line_out_t out_r, out_nxt;
   logic [15:0] win;
   logic signed [15:0] cos_v, sin_v;
   logic [31:0] gain;
   logic [`NUM_PATHS-1:0] root_done;
   logic [`NUM_PATHS-1:0][`MAG_W-1:0] wmag;
   logic [11:0] gap_r;
   logic [`LINE_W-1:0] last_line_r;
   // Ring spans three hops so arriving samples never hit the live frame
   assign rd_sum = {1'b0, base_r} + {2'b00, t_r};
   assign rd_addr = (rd_sum >= RING_D) ? `RING_AW'(rd_sum - RING_D) : rd_sum[`RING_AW-1:0];
   assign base_sum = {1'b0, wr_r} + BASE_OFS;
   assign frame_base = (base_sum >= RING_D) ? `RING_AW'(base_sum - RING_D)
      : base_sum[`RING_AW-1:0]; // [R02]
   assign acc_clr = (state_r == fft_ear_pkg::ST_IDLE) || (state_r == fft_ear_pkg::ST_EMIT);
   ear_tables u_tables (
      .clock(clock), .time_idx(t_r), .phase(phase_r), .line(k_r),
      .win(win), .cos_v(cos_v), .sin_v(sin_v), .gain(gain)
   );

   always_comb
   begin
      state_nxt = state_r;
      t_nxt = t_r;
      k_nxt = k_r;
      phase_nxt = phase_r;
      base_nxt = base_r;
      wr_nxt = wr_r;
      hop_nxt = hop_r;
      primed_nxt = primed_r;
      pend_nxt = pend_r;
      pend_base_nxt = pend_base_r;
      drop_nxt = 1'b0;
      v1_nxt = (state_r == fft_ear_pkg::ST_MAC);
      v2_nxt = v1_r;
      cos2_nxt = cos_v;
      sin2_nxt = sin_v;
      sq_go_nxt = (state_r == fft_ear_pkg::ST_SQUARE);
      out_nxt = out_r;
      out_nxt.valid = 1'b0;
      go = 1'b0;
      // Streams are taken as already aligned; one valid moves all four
      if (sample_in.valid) // [R01]
      begin
         wr_nxt = (wr_r == `RING_AW'(`RING_DEPTH - 1)) ? '0 : wr_r + `RING_AW'(1);
         hop_nxt = hop_r + `HOP_W'(1);
         if (hop_r == HOP_LAST)
         begin
            primed_nxt = 1'b1;
            go = primed_r; // [R02]
         end
      end
      consume = (state_r == fft_ear_pkg::ST_IDLE) && pend_r;
      // A new frame pends even while the old one is consumed in that cycle; an unstarted one is lost
      if (go)
      begin
         pend_nxt = 1'b1;
         pend_base_nxt = frame_base;
         drop_nxt = pend_r && !consume;
      end
      else if (consume)
         pend_nxt = 1'b0;
      case (state_r)
         fft_ear_pkg::ST_IDLE:
            if (pend_r)
            begin
               state_nxt = fft_ear_pkg::ST_MAC;
               base_nxt = pend_base_r;
               t_nxt = '0;
               k_nxt = '0;
               phase_nxt = '0;
            end
         fft_ear_pkg::ST_MAC:
         begin
            phase_nxt = phase_r + k_r; // [R04]
            t_nxt = t_r + `LINE_W'(1);
            if (t_r == T_LAST)
               state_nxt = fft_ear_pkg::ST_DRAIN;
         end
         fft_ear_pkg::ST_DRAIN:
            if (!v1_r && !v2_r)
               state_nxt = fft_ear_pkg::ST_SCALE;
         fft_ear_pkg::ST_SCALE: state_nxt = fft_ear_pkg::ST_SQUARE;
         fft_ear_pkg::ST_SQUARE: state_nxt = fft_ear_pkg::ST_SQRT;
         fft_ear_pkg::ST_SQRT:
            if (root_done[0])
               state_nxt = fft_ear_pkg::ST_WEIGHT;
         fft_ear_pkg::ST_WEIGHT: state_nxt = fft_ear_pkg::ST_EMIT;
         fft_ear_pkg::ST_EMIT:
         begin
            out_nxt.valid = 1'b1; // [R13]
            out_nxt.line = k_r;
            out_nxt.mag = wmag; // [R12]
            t_nxt = '0;
            phase_nxt = '0;
            if (k_r == K_LAST)
               state_nxt = fft_ear_pkg::ST_IDLE;
            else
            begin
               k_nxt = k_r + `LINE_W'(1);
               state_nxt = fft_ear_pkg::ST_MAC;
            end
         end
         default: state_nxt = fft_ear_pkg::ST_IDLE;
      endcase
      busy_nxt = (state_nxt != fft_ear_pkg::ST_IDLE);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_r <= fft_ear_pkg::ST_IDLE;
         t_r <= '0;
         k_r <= '0;
         phase_r <= '0;
         base_r <= '0;
         wr_r <= '0;
         hop_r <= '0;
         primed_r <= 1'b0;
         pend_r <= 1'b0;
         pend_base_r <= '0;
         drop_r <= 1'b0;
         v1_r <= 1'b0;
         v2_r <= 1'b0;
         cos2_r <= '0;
         sin2_r <= '0;
         sq_go_r <= 1'b0;
         busy_r <= 1'b0;
         out_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         t_r <= t_nxt;
         k_r <= k_nxt;
         phase_r <= phase_nxt;
         base_r <= base_nxt;
         wr_r <= wr_nxt;
         hop_r <= hop_nxt;
         primed_r <= primed_nxt;
         pend_r <= pend_nxt;
         pend_base_r <= pend_base_nxt;
         drop_r <= drop_nxt;
         v1_r <= v1_nxt;
         v2_r <= v2_nxt;
         cos2_r <= cos2_nxt;
         sin2_r <= sin2_nxt;
         sq_go_r <= sq_go_nxt;
         busy_r <= busy_nxt;
         out_r <= out_nxt;
      end
   end

   // One identical datapath per path; only the controller and the tables are shared
   generate
      for (genvar p = 0; p < `NUM_PATHS; p++)
      begin : g_path // [R11]
         logic signed [`SAMPLE_W-1:0] ring_m [`RING_DEPTH];
         logic signed [`SAMPLE_W-1:0] x_r, x_nxt;
         logic signed [`XW_W-1:0] xw_r, xw_nxt;
         logic signed [32:0] prod_w;
         logic signed [`ACC_W-1:0] acc_re_r, acc_re_nxt, acc_im_r, acc_im_nxt;
         logic signed [23:0] re_t, im_t;
         logic signed [63:0] re_f, im_f, re2, im2;
         logic signed [`SC_W-1:0] re_r, re_nxt, im_r, im_nxt;
         logic [63:0] sq_r, sq_nxt, wm_full;
         logic [`MAG_W-1:0] root, wmag_r, wmag_nxt;
         always_ff @(posedge clock)
            if (sample_in.valid)
               ring_m[wr_r] <= sample_in.path[p];
         always_comb
         begin
            x_nxt = ring_m[rd_addr];
            prod_w = x_r * $signed({1'b0, win});
            xw_nxt = `XW_W'(prod_w >>> `WIN_FRAC); // [R03]
            acc_re_nxt = acc_re_r;
            acc_im_nxt = acc_im_r;
            if (acc_clr)
            begin
               acc_re_nxt = '0;
               acc_im_nxt = '0;
            end
            else if (v2_r)
            begin
               acc_re_nxt = acc_re_r + `ACC_W'(xw_r * cos2_r); // [R04]
               acc_im_nxt = acc_im_r - `ACC_W'(xw_r * sin2_r);
            end
            // One shift drops 1/2048 and the sine scale; fraction bits kept for weak lines
            re_t = 24'(acc_re_r >>> (`DFT_SHIFT + `TRIG_FRAC - `OUT_FRAC)); // [R04]
            im_t = 24'(acc_im_r >>> (`DFT_SHIFT + `TRIG_FRAC - `OUT_FRAC));
            re_f = re_t * $signed({1'b0, FAC_Q}); // [R05] [R06]
            im_f = im_t * $signed({1'b0, FAC_Q});
            re_nxt = (state_r == fft_ear_pkg::ST_SCALE) ? `SC_W'(re_f >>> `FAC_FRAC) : re_r;
            im_nxt = (state_r == fft_ear_pkg::ST_SCALE) ? `SC_W'(im_f >>> `FAC_FRAC) : im_r;
            re2 = re_r * re_r;
            im2 = im_r * im_r;
            sq_nxt = (state_r == fft_ear_pkg::ST_SQUARE) ? 64'(re2 + im2) : sq_r; // [R10]
            wm_full = root * gain;
            wmag_nxt = (state_r == fft_ear_pkg::ST_WEIGHT)
               ? `MAG_W'(wm_full >> `GAIN_FRAC) : wmag_r; // [R08] [R10]
         end

         always_ff @(posedge clock)
         begin
            if (!rst_n)
            begin
               x_r <= '0;
               xw_r <= '0;
               acc_re_r <= '0;
               acc_im_r <= '0;
               re_r <= '0;
               im_r <= '0;
               sq_r <= '0;
               wmag_r <= '0;
            end
            else
            begin
               x_r <= x_nxt;
               xw_r <= xw_nxt;
               acc_re_r <= acc_re_nxt;
               acc_im_r <= acc_im_nxt;
               re_r <= re_nxt;
               im_r <= im_nxt;
               sq_r <= sq_nxt;
               wmag_r <= wmag_nxt;
            end
         end
         int_sqrt #(.IN_W(64)) u_sqrt (
            .clock(clock), .rst_n(rst_n), .start(sq_go_r),
            .radicand(sq_r), .root(root), .done(root_done[p])
         );
         assign wmag[p] = wmag_r;
      end
   endgenerate

   assign line_out = out_r;
   assign frame_drop = drop_r;
   assign busy = busy_r;

   // Assertion helper: clocks since the last line pulse; wrap is harmless
   always_ff @(posedge clock)
   begin
      gap_r <= (!rst_n || out_r.valid) ? 12'h000 : gap_r + 12'h001;
      if (out_r.valid)
         last_line_r <= out_r.line;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence mac_last;
      state_r == fft_ear_pkg::ST_MAC && t_r == T_LAST;
   endsequence
   sequence drain_then_scale;
      (state_r == fft_ear_pkg::ST_DRAIN) [*3] ##1 state_r == fft_ear_pkg::ST_SCALE;
   endsequence
   a_frame_start: assert property (go |-> hop_r == HOP_LAST && primed_r) // [R02]
      else $error("frame started off a hop boundary");
   a_frame_base: assert property (go |=> pend_r && pend_base_r == $past(frame_base)) // [R02]
      else $error("pending frame base wrong");
   a_mac_steps: assert property (state_r == fft_ear_pkg::ST_MAC && t_r != T_LAST
      |=> state_r == fft_ear_pkg::ST_MAC && t_r == $past(t_r) + `LINE_W'(1)) // [R04]
      else $error("accumulation skipped a sample");
   a_phase_step: assert property (state_r == fft_ear_pkg::ST_MAC && t_r != T_LAST
      |=> phase_r == $past(phase_r) + k_r) // [R04]
      else $error("twiddle phase step wrong");
   a_drain_len: assert property (mac_last |=> drain_then_scale) // [R04]
      else $error("pipeline drain length wrong");
   a_sqrt_bound: assert property ($rose(state_r == fft_ear_pkg::ST_SQRT)
      |-> ##[33:34] state_r == fft_ear_pkg::ST_WEIGHT) // [R10]
      else $error("root not ready in time");
   a_path_lock: assert property (root_done[0] |-> &root_done) // [R11]
      else $error("paths out of step");
   a_emit_strobe: assert property (state_r == fft_ear_pkg::ST_EMIT
      |=> out_r.valid && out_r.line == $past(k_r) && !$past(out_r.valid)) // [R13]
      else $error("line strobe or index wrong");
   a_line_next: assert property (out_r.valid && out_r.line != '0
      |-> gap_r == 12'(`LINE_GAP - 1) && out_r.line == last_line_r + `LINE_W'(1)) // [R13]
      else $error("line out of order or off pace");
   a_dc_zero: assert property (out_r.valid && out_r.line == '0 |-> out_r.mag == '0) // [R09]
      else $error("line zero not zero");
endmodule

// file: tb/line_sink.sv
/*
 Downstream model of the critical-band grouping stage: accepts every line
 pulse (it has no way to stall) and flags any line that breaks the order.
 Assumes fft_ear_pkg is compiled first and one shared clock.
*/
module line_sink (
   input wire logic clock,
   input wire logic rst_n,
   input wire fft_ear_pkg::line_out_t line_in,
   output logic order_err
);
   logic [10:0] next_line_r;

   // Lines must arrive 0..1024 and then restart for the next frame
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         next_line_r <= 11'h000;
         order_err <= 1'b0;
      end
      else if (line_in.valid)
      begin
         if (line_in.line !== next_line_r)
         begin
            order_err <= 1'b1;
         end
         next_line_r <= (line_in.line == 11'h400) ? 11'h000 : line_in.line + 11'h001;
      end
   end
endmodule

// file: tb/fft_ear_frontend_tb.sv
/*
 Self-checking bench of the ear-model front end: feeds one frame of tones
 plus noise, checks the first lines against a real-valued model, then
 forces a pending frame to be replaced. Assumes rtl/ sources and the sink.
*/
module fft_ear_frontend_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam real PI = 3.14159265358979;
   localparam real SPL = 92.0;
   localparam real NORM = 10000.0;
   localparam int NL = 20;
   localparam int BIN [4] = '{8, 12, 8, 16};
   localparam real AMP [4] = '{8000.0, 6000.0, 7000.0, 5000.0};

   logic clock = 1'b0;
   logic rst_n = 1'b0;
   fft_ear_pkg::sample_in_t sample_in = '0;
   fft_ear_pkg::line_out_t line_out;
   fft_ear_pkg::line_out_t exp_e;
   fft_ear_pkg::line_out_t exp_h;
   fft_ear_pkg::line_out_t exp_q [$];
   logic frame_drop;
   logic busy;
   logic order_err;
   int num_errors = 0;
   int compares = 0;
   int rx_count = 0;
   int drops = 0;
   real win [2048];
   int xs [4][2048];

   always #2.5 clock = ~clock;

   fft_ear_frontend #(.FULL_SCALE_SPL_LEVEL(SPL), .NORM(NORM)) fft_ear_frontend_i (
      .clock(clock),
      .rst_n(rst_n),
      .sample_in(sample_in),
      .line_out(line_out),
      .frame_drop(frame_drop),
      .busy(busy)
   );

   line_sink line_sink_i (
      .clock(clock),
      .rst_n(rst_n),
      .line_in(line_out),
      .order_err(order_err)
   );

   task automatic fail(input string msg);
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input logic [31:0] tol, input string what);
      logic [31:0] d;
      compares++;
      d = (seen > exp) ? seen - exp : exp - seen;
      if ($isunknown(seen) || d > tol)
      begin
         fail($sformatf("%s seen %0d expected %0d", what, seen, exp));
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && compares > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // All four paths in one strobe keeps reference and test aligned
   // Spacing of two clocks is far faster than 48 kHz, to keep the run short
   task automatic send(input int n);
      fft_ear_pkg::sample_in_t s;
      int v;
      s.valid = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         v = $rtoi(AMP[p] * $sin(2.0 * PI * BIN[p] * n / 2048.0));
         v = v + int'($urandom_range(0, 127)) - 64;
         if (n < 2048)
         begin
            xs[p][n] = v;
         end
         s.path[p] = v[15:0];
      end
      @(posedge clock);
      sample_in <= s;
      @(posedge clock);
      sample_in.valid <= 1'b0;
   endtask

   function automatic logic [31:0] expect_mag(input int p, input int k);
      real re;
      real im;
      real a;
      real f;
      real w;
      re = 0.0;
      im = 0.0;
      for (int t = 0; t < 2048; t++)
      begin
         a = 2.0 * PI * k * t / 2048.0;
         re += win[t] * xs[p][t] * $cos(a);
         im -= win[t] * xs[p][t] * $sin(a);
      end
      if (k == 0)
      begin
         return 32'h0000_0000;
      end
      f = k * 23.4375 / 1000.0;
      w = -0.6 * 3.64 * f ** (-0.8) + 6.5 * $exp(-0.6 * (f - 3.3) ** 2)
          - 0.001 * f ** 3.6;
      a = $sqrt(re * re + im * im) / 2048.0 * (10.0 ** (SPL / 20.0) / NORM);
      a = a * 10.0 ** (w / 20.0);
      return 32'($rtoi(a * 256.0 + 0.5));
   endfunction

   // Oldest note is matched against each of the first NL line pulses of the first frame
   always @(posedge clock)
   begin
      if (frame_drop === 1'b1)
      begin
         drops++;
      end
      if (line_out.valid === 1'b1 && rx_count < NL)
      begin
         if (exp_q.size() == 0)
         begin
            fail("line pulse with nothing expected");
         end
         else
         begin
            exp_h = exp_q.pop_front();
            check(32'(line_out.line), 32'(exp_h.line), 32'h0000_0000, "line index");
            for (int p = 0; p < 4; p++)
            begin
               // Fixed-point tables and truncation justify the slack
               check(line_out.mag[p], exp_h.mag[p],
                     exp_h.mag[p] / 16 + 256, "magnitude");
            end
         end
         rx_count++;
      end
   end

   initial
   begin
      void'($urandom(60));
      for (int t = 0; t < 2048; t++)
      begin
         win[t] = 0.5 * $sqrt(8.0 / 3.0) * (1.0 - $cos(2.0 * PI * t / 2047.0));
      end
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      for (int n = 0; n < 2047; n++)
      begin
         send(n);
      end
      @(negedge clock);
      check(32'(busy), 32'h0000_0000, 32'h0000_0000, "busy before full frame");
      send(2047);
      for (int k = 0; k < NL; k++)
      begin
         exp_e.valid = 1'b1;
         exp_e.line = 11'(k);
         for (int p = 0; p < 4; p++)
         begin
            exp_e.mag[p] = expect_mag(p, k);
         end
         exp_q.push_back(exp_e);
      end
      repeat (3) @(posedge clock);
      @(negedge clock);
      check(32'(busy), 32'h0000_0001, 32'h0000_0000, "busy after full frame");
      for (int i = 0; i < 60000 && rx_count < NL; i++)
      begin
         @(posedge clock);
      end
      if (rx_count < NL)
      begin
         fail("line pulses missing");
      end
      else
      begin
         // Boundary at 3072 only pends; the one at 4096 must replace it
         for (int n = 2048; n < 4095; n++)
         begin
            send(n);
         end
         @(negedge clock);
         check(32'(drops), 32'h0000_0000, 32'h0000_0000, "early frame drop");
         send(4095);
         repeat (3) @(posedge clock);
         @(negedge clock);
         check(32'(drops), 32'h0000_0001, 32'h0000_0000, "frame drop count");
      end
      check(32'(order_err), 32'h0000_0000, 32'h0000_0000, "line order");
      finish_test();
   end
endmodule
